// ===== src/data_space_access_unit.sv
// data-space decode, byte lanes and misaligned-word trap
`timescale 1ns/1ps
module data_space_access_unit
  import data_space_pkg::*;
#(
  parameter int unsigned RAM_BYTES = RAM_BYTES_DEFAULT,
  parameter logic [SFR_REGION_COUNT-1:0] SFR_REGION_MAP = {SFR_REGION_COUNT{1'b1}}
)
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic program_space_window_enable_in,
  input wire logic rd_req_in,
  input wire addr_mode_e rd_mode_in,
  input wire logic [15:0] rd_source_pointer_register_in,
  input wire logic [15:0] rd_direct_in,
  input wire logic rd_byte_in,
  input wire ext_op_e rd_op_in,
  input wire logic [15:0] rd_dest_old_in,
  input wire logic wr_req_in,
  input wire addr_mode_e wr_mode_in,
  input wire logic [15:0] wr_source_pointer_register_in,
  input wire logic [15:0] wr_direct_in,
  input wire logic wr_byte_in,
  input wire logic [15:0] wr_data_in,
  input wire logic [15:0] ram_rdata_in,
  input wire logic [15:0] sfr_rdata_in,
  input wire logic sfr_ack_in,
  input wire logic [15:0] psv_rdata_in,
  output logic ram_rd_en_out,
  output logic [12:0] ram_rd_index_out,
  output logic [12:0] ram_wr_index_out,
  output logic ram_we_lo_out,
  output logic ram_we_hi_out,
  output logic sfr_rd_en_out,
  output logic [10:0] sfr_rd_addr_out,
  output logic [10:0] sfr_wr_addr_out,
  output logic sfr_we_lo_out,
  output logic sfr_we_hi_out,
  output logic [15:0] mem_wdata_out,
  output logic psv_rd_en_out,
  output logic [14:0] psv_rd_addr_out,
  output logic [15:0] rd_ptr_next_out,
  output logic [15:0] wr_ptr_next_out,
  output logic rd_valid_out,
  output logic [15:0] rd_data_out,
  output logic [15:0] wreg_data_out,
  output logic address_error_trap_out
);

  localparam logic [16:0] RAM_END_X = 17'({1'b0, RAM_BASE}) + 17'(RAM_BYTES);

  function automatic logic sfr_region_implemented(input logic [15:0] ea);
    logic [5:0] region;
    region = ea[SFR_ADDR_W-1:SFR_REGION_SHIFT];
    return SFR_REGION_MAP[region];
  endfunction

  function automatic access_kind_e decode_kind(input logic [15:0] ea, input logic window_en);
    access_kind_e kind;
    kind = KIND_ZERO;
    if (ea[EA_W-1]) begin
      kind = window_en ? KIND_PSV : KIND_ZERO;
    end else if (ea <= SFR_LAST) begin
      kind = sfr_region_implemented(ea) ? KIND_SFR : KIND_ZERO;
    end else if (({1'b0, ea} >= {1'b0, RAM_BASE}) && ({1'b0, ea} < RAM_END_X)) begin
      kind = KIND_RAM;
    end else begin
      kind = KIND_ZERO;
    end
    return kind;
  endfunction

  function automatic logic [12:0] ram_index(input logic [15:0] ea);
    logic [15:0] offset;
    offset = ea - RAM_BASE;
    return offset[RAM_INDEX_W:1];
  endfunction

  // separate read and write address generators
  wire logic [15:0] rd_ea;
  wire logic [15:0] rd_ptr_next;
  wire logic [15:0] wr_ea;
  wire logic [15:0] wr_ptr_next;

  effective_address_unit u_read_agu (
    .mode_in(rd_mode_in),
    .source_pointer_register_in(rd_source_pointer_register_in),
    .direct_in(rd_direct_in),
    .byte_in(rd_byte_in),
    .effective_address_out(rd_ea),
    .pointer_next_out(rd_ptr_next)
  );

  effective_address_unit u_write_agu (
    .mode_in(wr_mode_in),
    .source_pointer_register_in(wr_source_pointer_register_in),
    .direct_in(wr_direct_in),
    .byte_in(wr_byte_in),
    .effective_address_out(wr_ea),
    .pointer_next_out(wr_ptr_next)
  );

  // request-stage decode
  wire access_kind_e rd_kind;
  wire access_kind_e wr_kind;
  wire logic rd_misaligned;
  wire logic wr_misaligned;
  wire logic wr_go;
  wire logic wr_lo_lane;
  wire logic wr_hi_lane;

  assign rd_kind = decode_kind(rd_ea, program_space_window_enable_in);
  assign wr_kind = decode_kind(wr_ea, program_space_window_enable_in);
  assign rd_misaligned = rd_req_in & ~rd_byte_in & rd_ea[0];
  assign wr_misaligned = wr_req_in & ~wr_byte_in & wr_ea[0];
  assign wr_go = wr_req_in & ~wr_misaligned;
  assign wr_lo_lane = wr_byte_in ? ~wr_ea[0] : 1'b1;
  assign wr_hi_lane = wr_byte_in ? wr_ea[0] : 1'b1;

  // stage-1 next values
  wire logic ram_rd_en_nxt;
  wire logic sfr_rd_en_nxt;
  wire logic psv_rd_en_nxt;
  wire logic ram_we_lo_nxt;
  wire logic ram_we_hi_nxt;
  wire logic sfr_we_lo_nxt;
  wire logic sfr_we_hi_nxt;
  wire logic [15:0] mem_wdata_nxt;

  assign ram_rd_en_nxt = rd_req_in & (rd_kind == KIND_RAM);
  assign sfr_rd_en_nxt = rd_req_in & (rd_kind == KIND_SFR);
  assign psv_rd_en_nxt = rd_req_in & (rd_kind == KIND_PSV);
  // writes into the window or unimplemented space never strobe
  assign ram_we_lo_nxt = wr_go & (wr_kind == KIND_RAM) & wr_lo_lane;
  assign ram_we_hi_nxt = wr_go & (wr_kind == KIND_RAM) & wr_hi_lane;
  assign sfr_we_lo_nxt = wr_go & (wr_kind == KIND_SFR) & wr_lo_lane;
  assign sfr_we_hi_nxt = wr_go & (wr_kind == KIND_SFR) & wr_hi_lane;
  // byte data is copied to both lanes so either strobe finds it
  assign mem_wdata_nxt = wr_byte_in ? {wr_data_in[7:0], wr_data_in[7:0]} : wr_data_in;

  // stage-1 bookkeeping for the read return
  logic rd_pend_r;
  access_kind_e rd_kind_r;
  logic rd_byte_r;
  logic rd_lane_r;
  logic rd_mis_r;
  ext_op_e rd_op_r;
  logic [15:0] rd_old_r;
  logic wr_mis_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ram_rd_en_out <= 1'b0;
      ram_rd_index_out <= INDEX_ZERO;
      ram_wr_index_out <= INDEX_ZERO;
      ram_we_lo_out <= 1'b0;
      ram_we_hi_out <= 1'b0;
      sfr_rd_en_out <= 1'b0;
      sfr_rd_addr_out <= SFR_ADDR_ZERO;
      sfr_wr_addr_out <= SFR_ADDR_ZERO;
      sfr_we_lo_out <= 1'b0;
      sfr_we_hi_out <= 1'b0;
      mem_wdata_out <= WORD_ZERO;
      psv_rd_en_out <= 1'b0;
      psv_rd_addr_out <= PSV_ADDR_ZERO;
      rd_ptr_next_out <= WORD_ZERO;
      wr_ptr_next_out <= WORD_ZERO;
    end else begin
      ram_rd_en_out <= ram_rd_en_nxt;
      ram_rd_index_out <= ram_index(rd_ea);
      ram_wr_index_out <= ram_index(wr_ea);
      ram_we_lo_out <= ram_we_lo_nxt;
      ram_we_hi_out <= ram_we_hi_nxt;
      sfr_rd_en_out <= sfr_rd_en_nxt;
      sfr_rd_addr_out <= {rd_ea[SFR_ADDR_W-1:1], 1'b0};
      sfr_wr_addr_out <= {wr_ea[SFR_ADDR_W-1:1], 1'b0};
      sfr_we_lo_out <= sfr_we_lo_nxt;
      sfr_we_hi_out <= sfr_we_hi_nxt;
      mem_wdata_out <= mem_wdata_nxt;
      psv_rd_en_out <= psv_rd_en_nxt;
      psv_rd_addr_out <= {rd_ea[PSV_ADDR_W-1:1], 1'b0};
      rd_ptr_next_out <= rd_req_in ? rd_ptr_next : rd_source_pointer_register_in;
      wr_ptr_next_out <= wr_req_in ? wr_ptr_next : wr_source_pointer_register_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rd_pend_r <= 1'b0;
      rd_kind_r <= KIND_ZERO;
      rd_byte_r <= 1'b0;
      rd_lane_r <= 1'b0;
      rd_mis_r <= 1'b0;
      rd_op_r <= EXT_LOAD_WORD;
      rd_old_r <= WORD_ZERO;
      wr_mis_r <= 1'b0;
    end else begin
      rd_pend_r <= rd_req_in;
      rd_kind_r <= rd_kind;
      rd_byte_r <= rd_byte_in;
      rd_lane_r <= rd_ea[0];
      rd_mis_r <= rd_misaligned;
      rd_op_r <= rd_op_in;
      rd_old_r <= rd_dest_old_in;
      wr_mis_r <= wr_misaligned;
    end
  end

  // read return: source select, zero fill, byte pick
  wire logic [15:0] rd_word;
  wire logic [7:0] rd_picked;
  wire logic [15:0] rd_value;
  wire logic [15:0] wreg_value;

  assign rd_word = (rd_kind_r == KIND_RAM) ? ram_rdata_in :
                   (rd_kind_r == KIND_SFR) ? (sfr_ack_in ? sfr_rdata_in : WORD_ZERO) :
                   (rd_kind_r == KIND_PSV) ? psv_rdata_in :
                   WORD_ZERO;
  assign rd_picked = rd_lane_r ? rd_word[15:8] : rd_word[7:0];
  assign rd_value = rd_byte_r ? {BYTE_ZERO, rd_picked} : rd_word;

  operand_extend_unit u_extend (
    .op_in(rd_op_r),
    .old_value_in(rd_old_r),
    .load_value_in(rd_value),
    .result_out(wreg_value)
  );

  // a misaligned read returns its data first and traps one cycle later
  logic rd_mis_done_r;
  wire logic trap_nxt;

  assign trap_nxt = rd_mis_done_r | wr_mis_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= WORD_ZERO;
      wreg_data_out <= WORD_ZERO;
      rd_mis_done_r <= 1'b0;
      address_error_trap_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_pend_r;
      rd_data_out <= rd_value;
      wreg_data_out <= wreg_value;
      rd_mis_done_r <= rd_mis_r;
      address_error_trap_out <= trap_nxt;
    end
  end

endmodule

// ===== src/data_space_pkg.sv
// shared constants and types for the data-space access unit
package data_space_pkg;

  localparam int unsigned EA_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned NEAR_FIELD_W = 13;
  localparam int unsigned RAM_INDEX_W = 13;
  localparam int unsigned SFR_ADDR_W = 11;
  localparam int unsigned PSV_ADDR_W = 15;
  localparam int unsigned SFR_REGION_BYTES = 32;
  localparam int unsigned SFR_REGION_SHIFT = 5;
  localparam int unsigned SFR_REGION_COUNT = 64;
  localparam int unsigned RAM_BYTES_DEFAULT = 16384;

  localparam logic [15:0] SFR_LAST = 16'h07FF;
  localparam logic [15:0] NEAR_LAST = 16'h1FFF;
  localparam logic [15:0] RAM_BASE = 16'h0800;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [12:0] INDEX_ZERO = 13'h0000;
  localparam logic [10:0] SFR_ADDR_ZERO = 11'h000;
  localparam logic [14:0] PSV_ADDR_ZERO = 15'h0000;

  typedef enum logic [1:0] {
    AM_INDIRECT_POSTINC = 2'b00,
    AM_INDIRECT = 2'b01,
    AM_NEAR_DIRECT = 2'b10,
    AM_FULL_DIRECT = 2'b11
  } addr_mode_e;

  typedef enum logic [1:0] {
    EXT_LOAD_WORD = 2'b00,
    EXT_LOAD_BYTE = 2'b01,
    EXT_SIGN = 2'b10,
    EXT_ZERO = 2'b11
  } ext_op_e;

  typedef enum logic [1:0] {
    KIND_ZERO = 2'b00,
    KIND_SFR = 2'b01,
    KIND_RAM = 2'b10,
    KIND_PSV = 2'b11
  } access_kind_e;

endpackage

// ===== src/effective_address_unit.sv
// one address generator: effective address and post-modified pointer
`timescale 1ns/1ps
module effective_address_unit
  import data_space_pkg::*;
(
  input wire addr_mode_e mode_in,
  input wire logic [15:0] source_pointer_register_in,
  input wire logic [15:0] direct_in,
  input wire logic byte_in,
  output logic [15:0] effective_address_out,
  output logic [15:0] pointer_next_out
);

  wire logic [15:0] step;
  wire logic [15:0] near_ea;

  assign step = byte_in ? STEP_BYTE : STEP_WORD;
  assign near_ea = {{(EA_W - NEAR_FIELD_W){1'b0}}, direct_in[NEAR_FIELD_W-1:0]};

  always_comb begin
    effective_address_out = source_pointer_register_in;
    pointer_next_out = source_pointer_register_in;
    unique case (mode_in)
      AM_INDIRECT_POSTINC: begin
        pointer_next_out = source_pointer_register_in + step;
      end
      AM_INDIRECT: begin
        pointer_next_out = source_pointer_register_in;
      end
      AM_NEAR_DIRECT: begin
        effective_address_out = near_ea;
      end
      AM_FULL_DIRECT: begin
        effective_address_out = direct_in;
      end
    endcase
  end

endmodule

// ===== src/operand_extend_unit.sv
// working-register update for byte loads, sign and zero extension
`timescale 1ns/1ps
module operand_extend_unit
  import data_space_pkg::*;
(
  input wire ext_op_e op_in,
  input wire logic [15:0] old_value_in,
  input wire logic [15:0] load_value_in,
  output logic [15:0] result_out
);

  always_comb begin
    result_out = load_value_in;
    unique case (op_in)
      EXT_LOAD_WORD: begin
        result_out = load_value_in;
      end
      EXT_LOAD_BYTE: begin
        result_out = {old_value_in[15:8], load_value_in[7:0]};
      end
      EXT_SIGN: begin
        result_out = {{BYTE_W{load_value_in[7]}}, load_value_in[7:0]};
      end
      EXT_ZERO: begin
        result_out = {BYTE_ZERO, load_value_in[7:0]};
      end
    endcase
  end

endmodule

// ===== testbench/mem_model.sv
// memory, register block and window partner model
`timescale 1ns/1ps
module mem_model (
  input wire logic clk_in,
  input wire logic ram_rd_en_in,
  input wire logic [12:0] ram_rd_index_in,
  input wire logic [12:0] ram_wr_index_in,
  input wire logic ram_we_lo_in,
  input wire logic ram_we_hi_in,
  input wire logic sfr_rd_en_in,
  input wire logic [10:0] sfr_rd_addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic psv_rd_en_in,
  input wire logic [14:0] psv_rd_addr_in,
  output logic [15:0] ram_rdata_out,
  output logic [15:0] sfr_rdata_out,
  output logic sfr_ack_out,
  output logic [15:0] psv_rdata_out
);
  logic [15:0] ram [0:8191];
  logic [15:0] sfr_word;
  logic [15:0] psv_word;
  initial for (int i = 0; i < 8192; i++) ram[i] = 16'h0000;
  assign sfr_word = {5'h15, sfr_rd_addr_in};
  assign psv_word = {1'b1, psv_rd_addr_in};
  // idle lines show the inverse so stale data never matches
  assign ram_rdata_out = ram_rd_en_in ? ram[ram_rd_index_in] : ~ram[ram_rd_index_in];
  assign sfr_rdata_out = sfr_rd_en_in ? sfr_word : ~sfr_word;
  assign sfr_ack_out = sfr_rd_en_in & ~sfr_rd_addr_in[3];
  assign psv_rdata_out = psv_rd_en_in ? psv_word : ~psv_word;
  always @(posedge clk_in) begin
    if (ram_we_lo_in) ram[ram_wr_index_in][7:0] <= wdata_in[7:0];
    if (ram_we_hi_in) ram[ram_wr_index_in][15:8] <= wdata_in[15:8];
  end
endmodule

// ===== testbench/data_space_access_unit_sva.sv
// assertion checker for the data-space access unit
`timescale 1ns/1ps
module data_space_access_unit_sva
  import data_space_pkg::*;
#(
  parameter int unsigned RAM_BYTES = RAM_BYTES_DEFAULT
)
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic program_space_window_enable_in,
  input wire logic rd_req_in,
  input wire addr_mode_e rd_mode_in,
  input wire logic [15:0] rd_source_pointer_register_in,
  input wire logic [15:0] rd_direct_in,
  input wire logic rd_byte_in,
  input wire logic wr_req_in,
  input wire addr_mode_e wr_mode_in,
  input wire logic [15:0] wr_direct_in,
  input wire logic wr_byte_in,
  input wire logic ram_rd_en_out,
  input wire logic [12:0] ram_rd_index_out,
  input wire logic ram_we_lo_out,
  input wire logic ram_we_hi_out,
  input wire logic psv_rd_en_out,
  input wire logic [15:0] rd_ptr_next_out,
  input wire logic [15:0] rd_data_out,
  input wire logic address_error_trap_out
);
  localparam int unsigned RAM_END = 32'h0000_0800 + RAM_BYTES;
  logic rfd, wfd, rram, wram;
  logic [15:0] roff;
  assign rfd = rd_req_in && rd_mode_in == AM_FULL_DIRECT;
  assign wfd = wr_req_in && wr_mode_in == AM_FULL_DIRECT;
  assign rram = rd_direct_in >= RAM_BASE && rd_direct_in < RAM_END;
  assign wram = wr_direct_in >= RAM_BASE && wr_direct_in < RAM_END;
  assign roff = rd_direct_in - RAM_BASE;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  property p_step;
    rd_req_in && rd_mode_in == AM_INDIRECT_POSTINC |=>
      rd_ptr_next_out == $past(rd_source_pointer_register_in) + ($past(rd_byte_in) ? STEP_BYTE : STEP_WORD);
  endproperty
  a_step: assert property (p_step) else $error("pointer step wrong");
  property p_lane;
    wfd && wr_byte_in && wram |=> ram_we_lo_out != $past(wr_direct_in[0]) && ram_we_hi_out == $past(wr_direct_in[0]);
  endproperty
  a_lane: assert property (p_lane) else $error("byte lane strobe wrong");
  property p_wtrap;
    wfd && !wr_byte_in && wr_direct_in[0] |=> !ram_we_lo_out && !ram_we_hi_out ##1 address_error_trap_out;
  endproperty
  a_wtrap: assert property (p_wtrap) else $error("misaligned write not trapped");
  property p_rtrap;
    rfd && !rd_byte_in && rd_direct_in[0] |-> ##3 address_error_trap_out;
  endproperty
  a_rtrap: assert property (p_rtrap) else $error("misaligned read not trapped");
  property p_gap;
    rfd && !rd_direct_in[15] && rd_direct_in >= RAM_END |-> ##2 rd_data_out == WORD_ZERO;
  endproperty
  a_gap: assert property (p_gap) else $error("gap read not zero");
  property p_win;
    rfd && rd_direct_in[15] |=> psv_rd_en_out == $past(program_space_window_enable_in);
  endproperty
  a_win: assert property (p_win) else $error("window enable ignored");
  property p_index;
    rfd && rram |=> ram_rd_en_out && ram_rd_index_out == $past(roff[13:1]);
  endproperty
  a_index: assert property (p_index) else $error("memory index wrong");
  property p_drop;
    wfd && wr_direct_in[15] && (wr_byte_in || !wr_direct_in[0]) |=>
      !ram_we_lo_out && !ram_we_hi_out ##1 !address_error_trap_out;
  endproperty
  a_drop: assert property (p_drop) else $error("window write not dropped");
endmodule
bind data_space_access_unit data_space_access_unit_sva #(.RAM_BYTES(RAM_BYTES)) u_sva (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .program_space_window_enable_in(program_space_window_enable_in),
  .rd_req_in(rd_req_in), .rd_mode_in(rd_mode_in), .rd_source_pointer_register_in(rd_source_pointer_register_in),
  .rd_direct_in(rd_direct_in), .rd_byte_in(rd_byte_in), .wr_req_in(wr_req_in), .wr_mode_in(wr_mode_in),
  .wr_direct_in(wr_direct_in), .wr_byte_in(wr_byte_in), .ram_rd_en_out(ram_rd_en_out),
  .ram_rd_index_out(ram_rd_index_out), .ram_we_lo_out(ram_we_lo_out), .ram_we_hi_out(ram_we_hi_out),
  .psv_rd_en_out(psv_rd_en_out), .rd_ptr_next_out(rd_ptr_next_out), .rd_data_out(rd_data_out),
  .address_error_trap_out(address_error_trap_out));

// ===== testbench/testbench.sv
// self-checking testbench for the data-space access unit
`timescale 1ns/1ps
module testbench;
  import data_space_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic win, rq, rb, wq, wb, ma, re, wl, wh, se, pe, rv, trap, swl, swh;
  addr_mode_e rm, wm;
  ext_op_e rop;
  logic [15:0] rp, rdir, rold, wp, wdir, wd, mr, ms, mp, wdo, rpn, wpn, rdat, wreg, a, v;
  logic [12:0] ri, wi;
  logic [10:0] sa, swa;
  logic [14:0] pa;
  logic [15:0] sh [0:8191];
  integer seed = 92;
  int err_total = 0;
  int checked = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  data_space_access_unit u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .program_space_window_enable_in(win),
    .rd_req_in(rq), .rd_mode_in(rm), .rd_source_pointer_register_in(rp), .rd_direct_in(rdir), .rd_byte_in(rb),
    .rd_op_in(rop), .rd_dest_old_in(rold), .wr_req_in(wq), .wr_mode_in(wm), .wr_source_pointer_register_in(wp),
    .wr_direct_in(wdir), .wr_byte_in(wb), .wr_data_in(wd), .ram_rdata_in(mr), .sfr_rdata_in(ms), .sfr_ack_in(ma),
    .psv_rdata_in(mp), .ram_rd_en_out(re), .ram_rd_index_out(ri), .ram_wr_index_out(wi), .ram_we_lo_out(wl),
    .ram_we_hi_out(wh), .sfr_rd_en_out(se), .sfr_rd_addr_out(sa), .sfr_wr_addr_out(swa), .sfr_we_lo_out(swl),
    .sfr_we_hi_out(swh), .mem_wdata_out(wdo), .psv_rd_en_out(pe), .psv_rd_addr_out(pa), .rd_ptr_next_out(rpn),
    .wr_ptr_next_out(wpn), .rd_valid_out(rv), .rd_data_out(rdat), .wreg_data_out(wreg),
    .address_error_trap_out(trap));
  mem_model u_mem (.clk_in(clk_sys_in), .ram_rd_en_in(re), .ram_rd_index_in(ri), .ram_wr_index_in(wi),
    .ram_we_lo_in(wl), .ram_we_hi_in(wh), .sfr_rd_en_in(se), .sfr_rd_addr_in(sa), .wdata_in(wdo),
    .psv_rd_en_in(pe), .psv_rd_addr_in(pa), .ram_rdata_out(mr), .sfr_rdata_out(ms), .sfr_ack_out(ma),
    .psv_rdata_out(mp));
  function automatic logic [15:0] word_at(logic [15:0] x);
    if (x[15]) return win ? {1'b1, x[14:1], 1'b0} : WORD_ZERO;
    if (x < RAM_BASE) return x[3] ? WORD_ZERO : {5'h15, x[10:1], 1'b0};
    if (x < 16'h4800) return sh[13'((x - RAM_BASE) >> 1)];
    return WORD_ZERO;
  endfunction
  function automatic logic [15:0] ext_of(ext_op_e o, logic [15:0] old, logic [15:0] d);
    case (o)
      EXT_LOAD_WORD: return d;
      EXT_LOAD_BYTE: return {old[15:8], d[7:0]};
      EXT_SIGN: return {{8{d[7]}}, d[7:0]};
      default: return {8'h00, d[7:0]};
    endcase
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(addr_mode_e m, logic [15:0] p, logic [15:0] d, logic b, ext_op_e o);
    logic [15:0] x, w, e, old;
    @(posedge clk_sys_in);
    x = m == AM_NEAR_DIRECT ? {3'h0, d[12:0]} : m == AM_FULL_DIRECT ? d : p;
    w = word_at(x);
    e = b ? {8'h00, x[0] ? w[15:8] : w[7:0]} : w;
    old = 16'($random(seed));
    rq <= 1'b1;
    rm <= m;
    rp <= p;
    rdir <= d;
    rb <= b;
    rop <= o;
    rold <= old;
    @(posedge clk_sys_in);
    rq <= 1'b0;
    #1 chk("ptr", m == AM_INDIRECT_POSTINC ? p + (b ? STEP_BYTE : STEP_WORD) : p, rpn);
    @(posedge clk_sys_in);
    #1 chk("rdata", e, rdat);
    chk("valid", 16'h0001, 16'(rv));
    chk("wreg", ext_of(o, old, e), wreg);
    @(posedge clk_sys_in);
    #1 chk("rtrap", 16'(!b && x[0]), 16'(trap));
  endtask
  task automatic wr(logic [15:0] d, logic b, logic [15:0] val);
    logic ram, ok, special_function_register;
    addr_mode_e m;
    ok = b || !d[0];
    ram = d >= RAM_BASE && d < 16'h4800;
    special_function_register = d <= SFR_LAST;
    m = (ram && ok && $random(seed) % 2 != 0) ? AM_INDIRECT_POSTINC : AM_FULL_DIRECT;
    @(posedge clk_sys_in);
    wq <= 1'b1;
    wm <= m;
    wp <= d;
    wdir <= d;
    wb <= b;
    wd <= val;
    @(posedge clk_sys_in);
    wq <= 1'b0;
    #1 chk("we_lo", 16'(ram && ok && !(b && d[0])), 16'(wl));
    chk("we_hi", 16'(ram && ok && !(b && !d[0])), 16'(wh));
    chk("sfr_we_lo", 16'(special_function_register && ok && !(b && d[0])), 16'(swl));
    chk("sfr_we_hi", 16'(special_function_register && ok && !(b && !d[0])), 16'(swh));
    chk("sfr_waddr", {5'h00, d[10:1], 1'b0}, {5'h00, swa});
    chk("wptr", m == AM_INDIRECT_POSTINC ? d + (b ? STEP_BYTE : STEP_WORD) : d, wpn);
    @(posedge clk_sys_in);
    #1 chk("wtrap", 16'(!ok), 16'(trap));
    if (ram && ok && (!b || !d[0])) sh[13'((d - RAM_BASE) >> 1)][7:0] = val[7:0];
    if (ram && ok && (!b || d[0])) sh[13'((d - RAM_BASE) >> 1)][15:8] = b ? val[7:0] : val[15:8];
  endtask
  task automatic stop_test();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    err_total++;
    stop_test();
  end
  initial begin
    {win, rq, rb, wq, wb} = 5'h00;
    {rp, rdir, rold, wp, wdir, wd} = {6{16'h0000}};
    rm = AM_FULL_DIRECT;
    wm = AM_FULL_DIRECT;
    rop = EXT_LOAD_WORD;
    for (int i = 0; i < 8192; i++) sh[i] = 16'h0000;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      a = RAM_BASE + 16'($random(seed) & 32'h3FFE);
      v = 16'($random(seed));
      wr(a, 1'b0, v);
      wr(a | 16'h0001, 1'b1, ~v);
      rd(AM_INDIRECT_POSTINC, a | 16'(i[1]), 16'h0000, i[0], ext_op_e'(i[3:2]));
      rd(AM_FULL_DIRECT, 16'h0000, a | 16'h0001, 1'b1, EXT_SIGN);
      rd(AM_FULL_DIRECT, 16'h0000, a, 1'b0, EXT_LOAD_WORD);
    end
    rd(AM_NEAR_DIRECT, 16'h0000, 16'hE000 | a, 1'b0, EXT_LOAD_WORD);
    rd(AM_FULL_DIRECT, 16'h0000, 16'h5001, 1'b1, EXT_ZERO);
    rd(AM_FULL_DIRECT, 16'h0000, 16'h0120, 1'b0, EXT_LOAD_WORD);
    rd(AM_FULL_DIRECT, 16'h0000, 16'h0128, 1'b0, EXT_LOAD_WORD);
    rd(AM_FULL_DIRECT, 16'h0000, 16'h8000, 1'b0, EXT_LOAD_WORD);
    win <= 1'b1;
    rd(AM_FULL_DIRECT, 16'h0000, 16'hC003, 1'b1, EXT_LOAD_BYTE);
    rd(AM_INDIRECT, 16'h0A01, 16'h0000, 1'b0, EXT_LOAD_WORD);
    wr(16'h0A01, 1'b0, 16'h1234);
    rd(AM_FULL_DIRECT, 16'h0000, 16'h0A00, 1'b0, EXT_LOAD_WORD);
    wr(16'h0125, 1'b1, 16'h00C3);
    wr(16'h9000, 1'b0, 16'h5A5A);
    wr(16'h5000, 1'b1, 16'h00A5);
    stop_test();
  end
endmodule
